// file: include/clk_src_pkg.sv
// What this block does
// - without external clock, logic runs from internal oscillator at nominally 15MHz.
// - accept external clock 8MHz to 10MHz and use it as system timing.
// - standstill flag rises exactly 2^20 system clocks after the last step.
// - first high on clock input stops oscillator and selects external clock.
// - fail-safe off: no fallback; a stopped external clock halts all clocked work.
// - fail-safe on: missing external clock returns to oscillator after 32-48 cycles.
// - fail-safe enable bit also enables the low-side short-to-supply detector.
// - enabled short-to-ground detection keeps working with no system clock.
// - clock input rejects spurious pulses of about 10ns.
package clk_src_pkg;
   // bus map
   localparam logic [11:0] CTRL_ADDR          = 12'h000;
   localparam logic [11:0] STATUS_ADDR        = 12'h004;
   localparam logic [11:0] STAND_CNT_ADDR     = 12'h008;
   // ctrl fields
   localparam int          CTRL_FAILSAFE_BIT  = 0;
   localparam int          CTRL_S2G_BIT       = 1;
   localparam logic        CTRL_FAILSAFE_RST  = 1'b0;
   localparam logic        CTRL_S2G_RST       = 1'b0;
   // status fields
   localparam int          STAT_EXT_SEL_BIT   = 0;
   localparam int          STAT_STANDSTILL_BIT = 1;
   localparam int          STAT_FALLBACK_BIT  = 2;
   // clock and oscillator rates
   localparam int          PCLK_MHZ           = 40;
   localparam int          PCLK_PERIOD_NS     = 25;
   localparam int          OSC_MHZ            = 15;
   localparam int          OSC_GCD            = 5;
   localparam logic [2:0]  OSC_STEP           = 3'(OSC_MHZ / OSC_GCD);
   localparam int          OSC_ACC_W          = 3;  // modulus 2^3 = 40/5
   // glitch filter length, pulses of this width are rejected
   localparam int          GLITCH_NS          = 10;
   localparam int          FILT_LEN = (GLITCH_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS + 1;
   // fail-safe timeout in internal ticks, inside 32..48
   localparam int          FAILSAFE_MIN       = 32;
   localparam int          FAILSAFE_MAX       = 48;
   localparam logic [5:0]  FAILSAFE_TICKS     = 6'((FAILSAFE_MIN + FAILSAFE_MAX) / 2);
   // standstill delay in system clocks
   localparam int          STAND_W            = 21;
   localparam logic [20:0] STANDSTILL_DEF     = 21'h100000;
endpackage

// file: hdl/clk_glitch_filter.sv
`timescale 1ns/1ps
module clk_glitch_filter
   import clk_src_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic raw_in,
   output logic      filt_r
);
   typedef struct packed {
      logic [FILT_LEN-1:0] hist;
      logic                filt;
   } filt_state_t;

   filt_state_t st_r;
   filt_state_t st_nxt;

   // output only changes once the input held one level for the whole history
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.hist = {st_r.hist[FILT_LEN-2:0], raw_in};
      if (&st_nxt.hist)
         st_nxt.filt = 1'b1;
      else if (~|st_nxt.hist)
         st_nxt.filt = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign filt_r = st_r.filt;

   glitch_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(filt_r) |-> $past(raw_in, 1) && $past(raw_in, 2))
      else $error("filtered clock rose on a short pulse");
endmodule // clk_glitch_filter

// file: hdl/system_clock_source_select.sv
`timescale 1ns/1ps
module system_clock_source_select
   import clk_src_pkg::*;
#(
   parameter logic [20:0] STANDSTILL_CLOCKS = STANDSTILL_DEF
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        clk_in,
   input  wire logic        step_in,
   output logic             sys_tick,
   output logic             ext_selected,
   output logic             osc_enable,
   output logic             standstill_flag,
   output logic             s2vs_detect_enable,
   output logic             s2g_detect_enable
);
   typedef struct packed {
      logic [OSC_ACC_W-1:0] osc_acc;
      logic                 osc_tick;
      logic                 osc_on;
      logic                 ext_sel;
      logic                 clk_prev;
      logic [5:0]           lost_cnt;
      logic                 fallback;
      logic                 step_prev;
      logic [STAND_W-1:0]   stand_cnt;
      logic                 standstill;
      logic                 clock_failsafe_enable;
      logic                 s2g_en;
      logic                 sys_tick;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } sel_state_t;

   sel_state_t st_r;
   sel_state_t st_nxt;
   logic       clk_filt;
   logic       ext_rise;
   logic       step_rise;
   logic       setup_ph;
   logic       wr_done;
   logic [OSC_ACC_W:0] osc_sum;

   clk_glitch_filter u_filt
   (
      .pclk    (pclk),
      .presetn (presetn),
      .raw_in  (clk_in),
      .filt_r  (clk_filt)
   );

   // edge and phase decodes
   assign ext_rise  = clk_filt & ~st_r.clk_prev;
   assign step_rise = step_in & ~st_r.step_prev;
   assign setup_ph  = psel & ~penable & ~st_r.pready;
   assign wr_done   = psel & penable & st_r.pready & pwrite;
   assign osc_sum   = {1'b0, st_r.osc_acc} + {1'b0, OSC_STEP};

   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.clk_prev  = clk_filt;
      st_nxt.step_prev = step_in;
      // internal oscillator model: 3 ticks every 8 pclk gives 15MHz
      st_nxt.osc_acc   = osc_sum[OSC_ACC_W-1:0];
      st_nxt.osc_tick  = osc_sum[OSC_ACC_W] & ~st_r.ext_sel; // stopped once external
      // source selection, sticky until reset or fail-safe fallback
      if (!st_r.ext_sel)
      begin
         st_nxt.lost_cnt = '0;
         if (ext_rise)
            st_nxt.ext_sel = 1'b1;
      end
      else if (ext_rise)
         st_nxt.lost_cnt = '0;
      else if (st_r.clock_failsafe_enable)
      begin
         // watchdog uses the oscillator rate even while it is gated off
         if (osc_sum[OSC_ACC_W])
            st_nxt.lost_cnt = st_r.lost_cnt + 6'h01;
         if (st_r.lost_cnt >= FAILSAFE_TICKS)
         begin
            st_nxt.ext_sel  = 1'b0;
            st_nxt.fallback = 1'b1;
            st_nxt.lost_cnt = '0;
         end
      end
      // oscillator enable has its own flop so the pin never sees a gate delay
      st_nxt.osc_on   = ~st_nxt.ext_sel;
      // with fail-safe off a dead external clock simply stops all ticks
      st_nxt.sys_tick = st_r.ext_sel ? ext_rise : st_r.osc_tick;
      // standstill timer counts system clocks from the last step
      if (step_rise)
      begin
         st_nxt.stand_cnt  = '0;
         st_nxt.standstill = 1'b0;
      end
      else if (st_r.sys_tick && !st_r.standstill)
      begin
         st_nxt.stand_cnt = st_r.stand_cnt + 21'h000001;
         if (st_nxt.stand_cnt == STANDSTILL_CLOCKS)
            st_nxt.standstill = 1'b1;
      end
      // apb slave: no wait states, answer registered during the setup cycle
      st_nxt.pready  = setup_ph;
      st_nxt.pslverr = 1'b0;
      if (setup_ph)
      begin
         st_nxt.prdata = 32'h00000000;
         unique case (paddr)
            CTRL_ADDR:
            begin
               st_nxt.prdata[CTRL_FAILSAFE_BIT] = st_r.clock_failsafe_enable;
               st_nxt.prdata[CTRL_S2G_BIT]      = st_r.s2g_en;
            end
            STATUS_ADDR:
            begin
               st_nxt.prdata[STAT_EXT_SEL_BIT]    = st_r.ext_sel;
               st_nxt.prdata[STAT_STANDSTILL_BIT] = st_r.standstill;
               st_nxt.prdata[STAT_FALLBACK_BIT]   = st_r.fallback;
            end
            STAND_CNT_ADDR:
               st_nxt.prdata = {11'h000, st_r.stand_cnt};
            default:
               st_nxt.pslverr = 1'b1; // unmapped address
         endcase
      end
      if (wr_done && paddr == CTRL_ADDR)
      begin
         st_nxt.clock_failsafe_enable = pwdata[CTRL_FAILSAFE_BIT];
         st_nxt.s2g_en                = pwdata[CTRL_S2G_BIT];
      end
      // write one clears fallback flag, a new fallback in the same cycle wins
      if (wr_done && paddr == STATUS_ADDR && pwdata[STAT_FALLBACK_BIT]
          && !(st_r.ext_sel && !st_nxt.ext_sel))
         st_nxt.fallback = 1'b0;
   end

   // reset puts selection back on the oscillator
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r                       <= '0;
         st_r.clock_failsafe_enable <= CTRL_FAILSAFE_RST;
         st_r.s2g_en                <= CTRL_S2G_RST;
         st_r.osc_on                <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // outputs straight from state flops
   assign prdata             = st_r.prdata;
   assign pready             = st_r.pready;
   assign pslverr            = st_r.pslverr;
   assign sys_tick           = st_r.sys_tick;
   assign ext_selected       = st_r.ext_sel;
   assign osc_enable         = st_r.osc_on;
   assign standstill_flag    = st_r.standstill;
   assign s2vs_detect_enable = st_r.clock_failsafe_enable;
   assign s2g_detect_enable  = st_r.s2g_en;                  // not gated by ticks

   osc_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.osc_tick |=> !st_r.osc_tick)
      else $error("oscillator ticks back to back");
   int_source_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ext_selected && !$past(ext_selected) |-> sys_tick == $past(st_r.osc_tick))
      else $error("internal source not driving system tick");
   ext_source_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_selected && ext_rise |=> sys_tick)
      else $error("external edge gave no system tick");
   first_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ext_selected && ext_rise |=> ext_selected && !osc_enable)
      else $error("no switchover on first clock high");
   no_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_selected && !s2vs_detect_enable |=> ext_selected)
      else $error("fallback without fail-safe");
   failsafe_win_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ext_selected) |->
         $past(st_r.lost_cnt) >= FAILSAFE_MIN && $past(st_r.lost_cnt) <= FAILSAFE_MAX)
      else $error("fallback outside 32 to 48 ticks");
   failsafe_do_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_selected && s2vs_detect_enable && st_r.lost_cnt >= FAILSAFE_TICKS && !ext_rise
      |=> !ext_selected)
      else $error("missing clock not caught");
   standstill_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(standstill_flag) |-> st_r.stand_cnt == STANDSTILL_CLOCKS)
      else $error("standstill at wrong count");
   s2g_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(wr_done) |-> $stable(s2g_detect_enable))
      else $error("short detect enable changed without write");
   reset_sel_a: assert property (@(posedge pclk)
      $rose(presetn) |-> !ext_selected && osc_enable)
      else $error("selection not cleared by reset");

   // guards on the oscillator gate, the halt, the watchdog, the control write and the timer
   osc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_selected |=> !st_r.osc_tick)
      else $error("oscillator ticks while external clock selected");
   ext_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_selected && !ext_rise |=> !sys_tick)
      else $error("system tick without external edge");
   lost_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_selected && ext_rise |=> st_r.lost_cnt == 6'h00)
      else $error("watchdog not restarted by external edge");
   ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && paddr == CTRL_ADDR |=> s2vs_detect_enable == $past(pwdata[CTRL_FAILSAFE_BIT]))
      else $error("fail-safe enable not taken from write");
   step_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_rise |=> !standstill_flag)
      else $error("standstill not cleared by step");
endmodule // system_clock_source_select

// file: testbench/ext_clock_source.sv
`timescale 1ns/1ps
module ext_clock_source (
   input  wire logic pclk,
   input  wire logic run,
   input  wire logic glitch,
   output logic      clk_in,
   output logic      driver_disable_input
);
   logic [1:0] phase_r;
   logic       keep;

   initial
   begin
      phase_r              = 2'h0;
      clk_in               = 1'b0;
      driver_disable_input = 1'b1;
   end

   // the clock runs one pclk longer than run, so the power stage is off before it stops
   assign keep = run | ~driver_disable_input;

   // 10MHz square wave at 50% duty while running, two pclk low then two high
   // pin is driven low, never left floating, whenever the clock is stopped and glitch is low
   // a one-pclk pulse stands in for a spurious spike on the line
   always @(posedge pclk)
   begin
      driver_disable_input <= ~run;
      phase_r <= keep ? phase_r + 2'h1 : 2'h0;
      clk_in  <= (keep & phase_r[1]) | glitch;
   end
endmodule // ext_clock_source

// file: testbench/system_clock_source_select_test.sv
`timescale 1ns/1ps
module system_clock_source_select_test import clk_src_pkg::*; ();
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, step_in = 1'b0, run = 1'b0, glitch = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, clk_in, sys_tick, ext_selected, osc_enable;
   logic        standstill_flag, s2vs_detect_enable, s2g_detect_enable;
   logic        driver_disable_input;
   localparam logic [20:0] STAND_SIM = 21'h000032; // short standstill delay for simulation
   int          miscompares = 0, total_checks = 0, ticks = 0;

   system_clock_source_select #(.STANDSTILL_CLOCKS(STAND_SIM)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .clk_in(clk_in), .step_in(step_in),
      .sys_tick(sys_tick), .ext_selected(ext_selected), .osc_enable(osc_enable),
      .standstill_flag(standstill_flag), .s2vs_detect_enable(s2vs_detect_enable),
      .s2g_detect_enable(s2g_detect_enable));

   ext_clock_source src_u (.pclk(pclk), .run(run), .glitch(glitch), .clk_in(clk_in),
      .driver_disable_input(driver_disable_input));

   // 40MHz clock and a running count of system clock pulses
   always #12.5 pclk = ~pclk;
   always @(posedge pclk)
      if (sys_tick === 1'b1) ticks <= ticks + 1;

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer, held until pready, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      cyc(1);
      penable <= 1'b1;
      cyc(1);
      while (pready !== 1'b1)
         cyc(1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(1);
   endtask

   task automatic ticks_in(input int n, output int t);
      int t0;
      t0 = ticks;
      cyc(n);
      t = ticks - t0;
   endtask

   task automatic wait_sel(input logic v, output int n);
      n = 0;
      while (ext_selected !== v && n < 400)
      begin
         cyc(1);
         n++;
      end
   endtask

   initial
   begin
      #(25 * 20000);
      miscompares++;
      complete_run;
   end

   initial
   begin
      logic [31:0] q, v;
      logic        e;
      int          n, t;
      void'($urandom(32'hDB34F750));
      cyc(10);
      presetn <= 1'b1;
      cyc(1);
      chk("ext_sel", 32'(ext_selected), 0);
      chk("osc_en", 32'(osc_enable), 1);
      // let the tick pipeline settle so the window sees whole oscillator periods
      cyc(2);
      ticks_in(80, n);
      chk("osc_ticks", 32'(n), 32'(80 * OSC_MHZ / PCLK_MHZ));
      apb(1'b0, 12'hFFC, 0, q, e);
      chk("unmapped_err", 32'(e), 1);
      chk("unmapped_rd", q, 0);
      // random control words reach the detector enables
      repeat (8)
      begin
         v = $urandom;
         apb(1'b1, CTRL_ADDR, v, q, e);
         chk("s2vs_en", 32'(s2vs_detect_enable), 32'(v[0]));
         chk("s2g_en", 32'(s2g_detect_enable), 32'(v[1]));
         apb(1'b0, CTRL_ADDR, 0, q, e);
         chk("ctrl_rd", q, {30'h0, v[1:0]});
      end
      apb(1'b1, CTRL_ADDR, 0, q, e);
      $display("test registers done");
      // standstill delay counted in system clocks
      step_in <= 1'b1;
      cyc(1);
      step_in <= 1'b0;
      cyc(1);
      n = ticks;
      cyc(1);
      chk("standstill_clear", 32'(standstill_flag), 0);
      t = 0;
      while (standstill_flag !== 1'b1 && t < 2000)
      begin
         cyc(1);
         t++;
      end
      chk("standstill_set", 32'(standstill_flag), 1);
      chk("standstill_ticks", 32'(ticks - n), 32'(STAND_SIM));
      $display("test standstill done");
      // a single short spike must not switch the source
      glitch <= 1'b1;
      cyc(1);
      glitch <= 1'b0;
      cyc(10);
      chk("glitch_sel", 32'(ext_selected), 0);
      run <= 1'b1;
      wait_sel(1'b1, n);
      chk("sel_latency", 32'(n < 12), 1);
      chk("osc_off", 32'(osc_enable), 0);
      // the switching edge makes no tick, so start counting once the edges run steadily
      cyc(4);
      ticks_in(40, n);
      chk("ext_ticks", 32'(n), 10);
      $display("test switchover done");
      // stopped clock without fail-safe halts everything
      run <= 1'b0;
      cyc(6);
      ticks_in(200, n);
      chk("halt_ticks", 32'(n), 0);
      chk("halt_sel", 32'(ext_selected), 1);
      chk("power_off", 32'(driver_disable_input), 1);
      run <= 1'b1;
      cyc(20);
      apb(1'b1, CTRL_ADDR, 32'h1, q, e);
      cyc(4);
      chk("fs_running", 32'(ext_selected), 1);
      run <= 1'b0;
      wait_sel(1'b0, n);
      // window in pclk; 12 extra cycles cover the last external edge and the filter
      chk("fs_window", 32'(n >= FAILSAFE_MIN * PCLK_MHZ / OSC_MHZ
                           && n <= FAILSAFE_MAX * PCLK_MHZ / OSC_MHZ + 12), 1);
      apb(1'b0, STATUS_ADDR, 0, q, e);
      chk("fs_status", 32'(q[STAT_FALLBACK_BIT]), 1);
      chk("fs_stat_sel", 32'(q[STAT_EXT_SEL_BIT]), 0);
      apb(1'b1, STATUS_ADDR, 32'h1 << STAT_FALLBACK_BIT, q, e);
      apb(1'b0, STATUS_ADDR, 0, q, e);
      chk("fs_cleared", 32'(q[STAT_FALLBACK_BIT]), 0);
      ticks_in(80, n);
      chk("fs_ticks", 32'(n), 32'(80 * OSC_MHZ / PCLK_MHZ));
      $display("test failsafe done");
      // reset after the external clock has stopped, with it still selected, returns to the oscillator
      run <= 1'b1;
      wait_sel(1'b1, n);
      run <= 1'b0;
      cyc(4);
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      cyc(2);
      chk("rst_sel", 32'(ext_selected), 0);
      chk("rst_osc", 32'(osc_enable), 1);
      chk("rst_s2vs", 32'(s2vs_detect_enable), 0);
      run <= 1'b1;
      wait_sel(1'b1, n);
      chk("resel", 32'(n < 12), 1);
      $display("test reset again done");
      complete_run;
   end
endmodule // system_clock_source_select_test
